/* File: cvec_master_ctrl.sv */
// cvec_master_ctrl: eight-input fixed-priority master request controller
module cvec_master_ctrl (
    // clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // request inputs, already synchronised
    input wire logic [7:0] request_inputs_i,
    input wire logic [7:0] request_mask_i,
    input wire logic [7:0] slave_present_i,
    // acknowledge and command strobes
    input wire logic ack1_i,
    input wire logic ack2_i,
    input wire logic end_of_service_command_i,
    // status and answers
    output logic maskable_irq_o,
    output logic [7:0] pending_request_status_o,
    output logic [7:0] in_service_status_o,
    output logic [2:0] win_idx_o,
    output logic win_slave_o,
    output logic [2:0] cascade_o,
    output logic cascade_oe_o,
    output logic [7:0] id_data_o,
    output logic id_data_oe_o
);

    logic [7:0] allow;
    logic [7:0] cand;
    logic [7:0] grant;
    logic [2:0] cand_idx;
    logic [7:0] next_pend;
    logic [7:0] next_isr;
    logic next_irq;
    logic [2:0] next_win;
    logic next_slave;
    logic [2:0] next_casc;
    logic next_casc_oe;
    logic [7:0] next_id;
    logic next_id_oe;

    // ------------------------------------------------------------
    // priority: input 0 highest; an input may interrupt only above all in service
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < cvec_pkg::NUM_REQ; g++) begin : g_allow
            assign allow[g] = ~|in_service_status_o[g:0];
        end
    endgenerate

    // a one blocks its input, a zero enables it
    assign cand = pending_request_status_o & ~request_mask_i & allow;
    assign grant = cand & (~cand + 8'h01);

    // encode the winning input number
    always_comb begin
        cand_idx = 3'h0;
        for (int i = cvec_pkg::NUM_REQ - 1; i >= 0; i--) begin
            if (cand[i]) begin
                cand_idx = i[2:0];
            end
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        // pending follows the lines; granted bit drops during acknowledge
        next_pend = request_inputs_i & ~(ack1_i ? grant : 8'h00);
        next_isr = in_service_status_o;
        if (end_of_service_command_i) begin
            next_isr = next_isr & (next_isr - 8'h01);
        end
        if (ack1_i) begin
            next_isr = next_isr | grant;
        end
        next_irq = |cand & ~ack1_i & ~ack2_i;
        next_win = win_idx_o;
        next_slave = win_slave_o;
        next_casc = cascade_o;
        next_casc_oe = cascade_oe_o;
        next_id = id_data_o;
        next_id_oe = 1'b0;
        if (ack1_i) begin
            next_win = cand_idx;
            next_slave = slave_present_i[cand_idx];
            // cascade code names the slave that answers the second pulse
            next_casc = cand_idx;
            next_casc_oe = slave_present_i[cand_idx];
            // byte driven only for a direct input: number in low bits
            next_id = {5'h00, cand_idx};
            next_id_oe = ~slave_present_i[cand_idx];
        end
        if (ack2_i) begin
            next_casc_oe = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pending_request_status_o <= cvec_pkg::STATUS_RESET;
            in_service_status_o <= cvec_pkg::STATUS_RESET;
            maskable_irq_o <= 1'b0;
            win_idx_o <= 3'h0;
            win_slave_o <= 1'b0;
            cascade_o <= 3'h0;
            cascade_oe_o <= 1'b0;
            id_data_o <= 8'h00;
            id_data_oe_o <= 1'b0;
        end else begin
            pending_request_status_o <= next_pend;
            in_service_status_o <= next_isr;
            maskable_irq_o <= next_irq;
            win_idx_o <= next_win;
            win_slave_o <= next_slave;
            cascade_o <= next_casc;
            cascade_oe_o <= next_casc_oe;
            id_data_o <= next_id;
            id_data_oe_o <= next_id_oe;
        end
    end

endmodule // cvec_master_ctrl

/* File: cvec_pkg.sv */
// cvec_pkg: shared constants for the interrupt vectoring block
package cvec_pkg;

    // ------------------------------------------------------------
    // port addresses and command bytes
    // ------------------------------------------------------------
    localparam logic [15:0] CMD_PORT = 16'h00c0;
    localparam logic [15:0] MASK_PORT = 16'h00c2;
    localparam logic [7:0] RD_PENDING_CMD = 8'h0a;
    localparam logic [7:0] RD_SERVICE_CMD = 8'h0b;
    localparam logic [7:0] END_OF_SERVICE_CMD = 8'h20;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int NUM_REQ = 8;
    localparam int IDX_W = 3;
    localparam int ADDR_W = 20;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ------------------------------------------------------------
    // vectors: fixed non-maskable slot, maskable slot is id times four
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] NMI_VECTOR = 20'h00008;
    localparam int VEC_SHIFT = 2;

    // ------------------------------------------------------------
    // processor interrupt sequence states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CVEC_IDLE,
        CVEC_NMI_PUSH,
        CVEC_NMI_CALL,
        CVEC_ACK1,
        CVEC_ACK2,
        CVEC_INT_PUSH,
        CVEC_INT_CALL
    } cvec_state_t;

endpackage

/* File: cvec_slave_model.sv */
// cvec_slave_model: behavioural cascaded slave controller answering the master
module cvec_slave_model #(
    parameter logic [2:0] SLAVE_ID = 3'h7,
    parameter logic [2:0] MASTER_LINE = 3'h4,
    parameter logic [2:0] SLAVE_INPUT = 3'h2
) (
    // clock
    input wire logic clock_i,
    // cascade code from the master
    input wire logic [2:0] cascade_i,
    input wire logic cascade_oe_i,
    // identifier byte to the processor
    output logic [7:0] ext_id_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] last_q = 8'h00;

    // answer only when named; otherwise a toggling pattern so a stale byte never passes
    always_comb begin
        if (cascade_oe_i && cascade_i == MASTER_LINE) begin
            ext_id_o = {2'b00, SLAVE_ID, SLAVE_INPUT};
        end else begin
            ext_id_o = ~last_q;
        end
    end

    // remember the bus value to invert it next cycle
    always_ff @(posedge clock_i) begin
        last_q <= ext_id_o;
    end
endmodule // cvec_slave_model

/* File: cvec_top.sv */
// cvec_top: processor interrupt vectoring with on-board master controller
module cvec_top (
    // clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // interrupt pins
    input wire logic nmi_i,
    input wire logic [7:0] request_inputs_i,
    input wire logic [7:0] slave_present_i,
    // processor core handshake
    input wire logic boundary_i,
    input wire logic set_enable_i,
    input wire logic clear_enable_i,
    input wire logic return_i,
    input wire logic restored_enable_i,
    input wire logic [7:0] ext_id_i,
    // port access
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [15:0] io_addr_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    // sequence outputs
    output logic int_ack_o,
    output logic push_flags_o,
    output logic pushed_enable_o,
    output logic call_o,
    output logic [19:0] vector_o,
    output logic enable_flag_o,
    output logic busy_o,
    output logic maskable_irq_in_o,
    // controller bus side
    output logic [2:0] cascade_o,
    output logic cascade_oe_o,
    output logic [7:0] id_data_o,
    output logic id_data_oe_o
);

    // ------------------------------------------------------------
    // pin synchronisers: three stages, a change counts once 2 and 3 agree
    // ------------------------------------------------------------
    logic [8:0] sync1;
    logic [8:0] sync2;
    logic [8:0] sync3;
    logic [8:0] filt;
    logic [8:0] next_filt;
    logic [8:0] raw_pins;

    assign raw_pins = {nmi_i, request_inputs_i};

    genvar g;
    generate
        for (g = 0; g < 9; g++) begin : g_filt
            // only stages 2 and 3 are compared; stage 1 may be metastable
            assign next_filt[g] = (sync2[g] == sync3[g]) ? sync3[g] : filt[g];
        end
    endgenerate

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1 <= 9'h000;
            sync2 <= 9'h000;
            sync3 <= 9'h000;
            filt <= 9'h000;
        end else begin
            sync1 <= raw_pins;
            sync2 <= sync1;
            sync3 <= sync2;
            filt <= next_filt;
        end
    end

    // ------------------------------------------------------------
    // register port state
    // ------------------------------------------------------------
    logic [7:0] request_mask;
    logic read_select_command;
    logic [7:0] next_mask;
    logic next_sel;
    logic [7:0] next_rdata;
    logic eoi_strobe;
    logic [7:0] pend_stat;
    logic [7:0] isr_stat;
    logic cmd_hit;
    logic mask_hit;

    assign cmd_hit = (io_addr_i == cvec_pkg::CMD_PORT);
    assign mask_hit = (io_addr_i == cvec_pkg::MASK_PORT);
    assign eoi_strobe = io_wr_i & cmd_hit & (io_wdata_i == cvec_pkg::END_OF_SERVICE_CMD);

    // decode writes and reads; read data shows one cycle after the strobe
    always_comb begin
        next_mask = request_mask;
        next_sel = read_select_command;
        next_rdata = io_rdata_o;
        if (io_wr_i && mask_hit) begin
            next_mask = io_wdata_i;
        end else if (io_wr_i && cmd_hit) begin
            if (io_wdata_i == cvec_pkg::RD_PENDING_CMD) begin
                next_sel = 1'b0;
            end else if (io_wdata_i == cvec_pkg::RD_SERVICE_CMD) begin
                next_sel = 1'b1;
            end
        end
        if (io_rd_i) begin
            if (cmd_hit) begin
                next_rdata = read_select_command ? isr_stat : pend_stat;
            end else if (mask_hit) begin
                next_rdata = request_mask;
            end else begin
                next_rdata = cvec_pkg::UNMAPPED_READ;
            end
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            request_mask <= cvec_pkg::MASK_RESET;
            read_select_command <= 1'b0;
            io_rdata_o <= 8'h00;
        end else begin
            request_mask <= next_mask;
            read_select_command <= next_sel;
            io_rdata_o <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // master controller
    // ------------------------------------------------------------
    cvec_pkg::cvec_state_t state;
    cvec_pkg::cvec_state_t next_state;
    logic win_slave;
    logic irq_level;

    cvec_master_ctrl u_ctrl (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .request_inputs_i(filt[7:0]),
        .request_mask_i(request_mask),
        .slave_present_i(slave_present_i),
        .ack1_i(state == cvec_pkg::CVEC_ACK1),
        .ack2_i(state == cvec_pkg::CVEC_ACK2),
        .end_of_service_command_i(eoi_strobe),
        .maskable_irq_o(irq_level),
        .pending_request_status_o(pend_stat),
        .in_service_status_o(isr_stat),
        .win_idx_o(),
        .win_slave_o(win_slave),
        .cascade_o(cascade_o),
        .cascade_oe_o(cascade_oe_o),
        .id_data_o(id_data_o),
        .id_data_oe_o(id_data_oe_o)
    );

    // ------------------------------------------------------------
    // processor interrupt sequencer
    // ------------------------------------------------------------
    logic nmi_prev;
    logic nmi_pend;
    logic enable_flag;
    logic [7:0] id_byte;
    logic next_nmi_pend;
    logic next_enable;
    logic [7:0] next_id_byte;
    logic next_ack;
    logic next_push;
    logic next_pushed;
    logic next_call;
    logic [19:0] next_vector;

    always_comb begin
        next_state = state;
        next_enable = enable_flag;
        next_id_byte = id_byte;
        next_pushed = pushed_enable_o;
        next_vector = vector_o;
        next_push = 1'b0;
        next_call = 1'b0;
        // edge latch: a new edge in the take cycle is kept, set wins
        next_nmi_pend = nmi_pend;
        if (state == cvec_pkg::CVEC_NMI_PUSH) begin
            next_nmi_pend = 1'b0;
        end
        if (filt[8] && !nmi_prev) begin
            next_nmi_pend = 1'b1;
        end
        // software enable control and restore on return
        if (set_enable_i) begin
            next_enable = 1'b1;
        end else if (clear_enable_i) begin
            next_enable = 1'b0;
        end
        if (return_i) begin
            next_enable = restored_enable_i;
        end
        case (state)
            cvec_pkg::CVEC_IDLE: begin
                // boundary covers instruction end and each element move
                if (boundary_i && nmi_pend) begin
                    next_state = cvec_pkg::CVEC_NMI_PUSH;
                end else if (boundary_i && irq_level && enable_flag) begin
                    next_state = cvec_pkg::CVEC_ACK1;
                end
            end
            cvec_pkg::CVEC_NMI_PUSH: begin
                next_push = 1'b1;
                next_pushed = enable_flag;
                next_enable = 1'b0;
                next_state = cvec_pkg::CVEC_NMI_CALL;
            end
            cvec_pkg::CVEC_NMI_CALL: begin
                next_call = 1'b1;
                next_vector = cvec_pkg::NMI_VECTOR;
                next_state = cvec_pkg::CVEC_IDLE;
            end
            cvec_pkg::CVEC_ACK1: begin
                next_state = cvec_pkg::CVEC_ACK2;
            end
            cvec_pkg::CVEC_ACK2: begin
                // slave byte carries identity 5:3 and input 2:0 unchanged
                next_id_byte = win_slave ? ext_id_i : id_data_o;
                next_state = cvec_pkg::CVEC_INT_PUSH;
            end
            cvec_pkg::CVEC_INT_PUSH: begin
                next_push = 1'b1;
                next_pushed = enable_flag;
                next_enable = 1'b0;
                next_state = cvec_pkg::CVEC_INT_CALL;
            end
            cvec_pkg::CVEC_INT_CALL: begin
                next_call = 1'b1;
                next_vector = 20'({id_byte, 2'b00});
                next_state = cvec_pkg::CVEC_IDLE;
            end
            default: begin
                next_state = cvec_pkg::CVEC_IDLE;
            end
        endcase
        next_ack = (next_state == cvec_pkg::CVEC_ACK1) || (next_state == cvec_pkg::CVEC_ACK2);
    end

    // sequencer state and registered outputs
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= cvec_pkg::CVEC_IDLE;
            nmi_prev <= 1'b0;
            nmi_pend <= 1'b0;
            enable_flag <= 1'b0;
            id_byte <= 8'h00;
            int_ack_o <= 1'b0;
            push_flags_o <= 1'b0;
            pushed_enable_o <= 1'b0;
            call_o <= 1'b0;
            vector_o <= 20'h00000;
            enable_flag_o <= 1'b0;
            busy_o <= 1'b0;
            maskable_irq_in_o <= 1'b0;
        end else begin
            state <= next_state;
            nmi_prev <= filt[8];
            nmi_pend <= next_nmi_pend;
            enable_flag <= next_enable;
            id_byte <= next_id_byte;
            int_ack_o <= next_ack;
            push_flags_o <= next_push;
            pushed_enable_o <= next_pushed;
            call_o <= next_call;
            vector_o <= next_vector;
            enable_flag_o <= next_enable;
            busy_o <= (next_state != cvec_pkg::CVEC_IDLE);
            maskable_irq_in_o <= irq_level;
        end
    end

endmodule // cvec_top

/* File: cvec_top_chk.sv */
// cvec_top_chk: port-level assertions for the interrupt vectoring block
module cvec_top_chk (
    // clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // watched ports
    input wire logic [7:0] ext_id_i,
    input wire logic int_ack_o,
    input wire logic push_flags_o,
    input wire logic call_o,
    input wire logic [19:0] vector_o,
    input wire logic enable_flag_o,
    input wire logic cascade_oe_o,
    input wire logic [7:0] id_data_o,
    input wire logic id_data_oe_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    // ----------------------------------------
    // acknowledge sequence steps
    // ----------------------------------------
    sequence ack_pair_s;
        int_ack_o ##1 int_ack_o ##1 !int_ack_o;
    endsequence
    sequence push_call_s;
        push_flags_o && !call_o ##1 call_o && !push_flags_o;
    endsequence

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    ack_pair_a: assert property ($rose(int_ack_o) |-> ack_pair_s)
        else $error("acknowledge is not two cycles");
    ack_push_a: assert property ($rose(int_ack_o) |-> ##3 push_call_s)
        else $error("push and call do not follow acknowledge");
    push_clears_a: assert property (push_flags_o |-> !enable_flag_o)
        else $error("enable flag still set at push");
    ack_enabled_a: assert property ($rose(int_ack_o) |-> enable_flag_o)
        else $error("acknowledge with enable flag clear");
    master_vec_a: assert property (call_o && $past(id_data_oe_o, 3) |-> vector_o == {10'h000, $past(id_data_o, 3), 2'b00})
        else $error("master vector is not id times four");
    slave_vec_a: assert property (call_o && $past(cascade_oe_o, 3) |-> vector_o == {10'h000, $past(ext_id_i, 3), 2'b00})
        else $error("slave vector is not id times four");
    nmi_vec_a: assert property (call_o && !$past(int_ack_o, 4) |-> vector_o == cvec_pkg::NMI_VECTOR)
        else $error("non-maskable vector wrong");
    id_slot_a: assert property (id_data_oe_o |-> int_ack_o && $past(int_ack_o) && !cascade_oe_o)
        else $error("master byte outside second acknowledge");
    cascade_slot_a: assert property (cascade_oe_o |-> int_ack_o && !id_data_oe_o)
        else $error("cascade code outside acknowledge");
    id_upper_a: assert property (id_data_oe_o |-> id_data_o[7:3] == 5'h00)
        else $error("master byte upper bits not zero");
endmodule // cvec_top_chk

/* File: cvec_top_test.sv */
// cvec_top_test: directed testbench for the interrupt vectoring block
module cvec_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0, resetn_i = 1'b0, nmi_i = 1'b0, boundary_i = 1'b0;
    logic set_enable_i = 1'b0, clear_enable_i = 1'b0, return_i = 1'b0, restored_enable_i = 1'b0;
    logic io_wr_i = 1'b0, io_rd_i = 1'b0, int_ack_o, push_flags_o, pushed_enable_o, call_o;
    logic enable_flag_o, busy_o, maskable_irq_in_o, cascade_oe_o, id_data_oe_o;
    logic [7:0] request_inputs_i = 8'h00, slave_present_i = 8'h00, io_wdata_i = 8'h00;
    logic [7:0] ext_id_i, io_rdata_o, id_data_o;
    logic [15:0] io_addr_i = 16'h0000;
    logic [19:0] vector_o;
    logic [2:0] cascade_o;
    int bad_count = 0, num_checks = 0;

    cvec_top u_cvec_top (.clock_i(clock_i), .resetn_i(resetn_i), .nmi_i(nmi_i),
        .request_inputs_i(request_inputs_i), .slave_present_i(slave_present_i), .boundary_i(boundary_i),
        .set_enable_i(set_enable_i), .clear_enable_i(clear_enable_i), .return_i(return_i),
        .restored_enable_i(restored_enable_i), .ext_id_i(ext_id_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
        .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .int_ack_o(int_ack_o),
        .push_flags_o(push_flags_o), .pushed_enable_o(pushed_enable_o), .call_o(call_o), .vector_o(vector_o),
        .enable_flag_o(enable_flag_o), .busy_o(busy_o), .maskable_irq_in_o(maskable_irq_in_o),
        .cascade_o(cascade_o), .cascade_oe_o(cascade_oe_o), .id_data_o(id_data_o), .id_data_oe_o(id_data_oe_o));
    cvec_slave_model u_cvec_slave_model (.clock_i(clock_i), .cascade_i(cascade_o), .cascade_oe_i(cascade_oe_o),
        .ext_id_o(ext_id_i));

    // ----------------------------------------
    // clock, shared tasks
    // ----------------------------------------
    initial begin
        forever #20 clock_i = ~clock_i;
    end
    // inputs always move 1 ns after a rising edge
    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk_val(input string what, input logic [19:0] exp, input logic [19:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // an idle cycle after each strobe keeps back-to-back calls from clashing
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        io_addr_i = a;
        io_wdata_i = d;
        pulse(io_wr_i);
        step(1);
    endtask
    task automatic look(input logic [15:0] a, input logic [7:0] exp);
        io_addr_i = a;
        pulse(io_rd_i);
        chk_val("read data", {12'h000, exp}, {12'h000, io_rdata_o});
        step(1);
    endtask
    task automatic sel(input logic [7:0] cmd, input logic [7:0] exp);
        wr(cvec_pkg::CMD_PORT, cmd);
        look(cvec_pkg::CMD_PORT, exp);
    endtask
    // one boundary, then the whole sequence cycle by cycle
    task automatic take(input logic is_nmi, input logic [7:0] id, input logic via_slave, input logic [2:0] line);
        int p;
        p = is_nmi ? 2 : 4;
        pulse(boundary_i);
        // k counts cycles after the boundary edge; the first look needs no extra wait
        for (int k = 1; k <= 5; k++) begin
            if (k > 1) step(1);
            chk_bit("ack", !is_nmi && k <= 2, int_ack_o);
            chk_bit("push", k == p, push_flags_o);
            chk_bit("call", k == p + 1, call_o);
            chk_bit("id drive", !is_nmi && !via_slave && k == 2, id_data_oe_o);
            chk_bit("cascade drive", !is_nmi && via_slave && k == 2, cascade_oe_o);
            if (k == 2 && via_slave) chk_val("cascade code", {17'h00000, line}, {17'h00000, cascade_o});
            if (k == 2 && !via_slave && !is_nmi) chk_val("id byte", {12'h000, id}, {12'h000, id_data_o});
            // every scenario sets the enable flag before its boundary, so a one is pushed
            if (k == p) chk_bit("pushed enable", 1'b1, pushed_enable_o);
        end
        chk_bit("enable after", 1'b0, enable_flag_o);
        chk_val("vector", is_nmi ? cvec_pkg::NMI_VECTOR : {10'h000, id, 2'b00}, vector_o);
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        step(8);
        resetn_i = 1'b1;
        step(1);
        chk_bit("enable reset", 1'b0, enable_flag_o);
        look(cvec_pkg::MASK_PORT, cvec_pkg::MASK_RESET);
        look(16'h00c4, cvec_pkg::UNMAPPED_READ);
        sel(cvec_pkg::RD_PENDING_CMD, 8'h00);
        sel(cvec_pkg::RD_SERVICE_CMD, 8'h00);
        $display("test reset values done");
        wr(cvec_pkg::MASK_PORT, 8'h20);
        look(cvec_pkg::MASK_PORT, 8'h20);
        request_inputs_i = 8'h20;
        step(8);
        sel(cvec_pkg::RD_PENDING_CMD, 8'h20);
        chk_bit("masked request", 1'b0, maskable_irq_in_o);
        wr(cvec_pkg::MASK_PORT, 8'h00);
        step(4);
        chk_bit("unmasked request", 1'b1, maskable_irq_in_o);
        $display("test mask done");
        pulse(boundary_i);
        step(2);
        chk_bit("busy while disabled", 1'b0, busy_o);
        pulse(set_enable_i);
        step(4);
        chk_bit("busy without boundary", 1'b0, busy_o);
        take(1'b0, 8'h05, 1'b0, 3'h0);
        sel(cvec_pkg::RD_SERVICE_CMD, 8'h20);
        request_inputs_i = 8'h28;
        pulse(set_enable_i);
        step(8);
        take(1'b0, 8'h03, 1'b0, 3'h0);
        sel(cvec_pkg::RD_SERVICE_CMD, 8'h28);
        wr(cvec_pkg::CMD_PORT, cvec_pkg::END_OF_SERVICE_CMD);
        sel(cvec_pkg::RD_SERVICE_CMD, 8'h20);
        wr(cvec_pkg::CMD_PORT, cvec_pkg::END_OF_SERVICE_CMD);
        sel(cvec_pkg::RD_SERVICE_CMD, 8'h00);
        request_inputs_i = 8'h00;
        $display("test direct service done");
        restored_enable_i = 1'b1;
        pulse(return_i);
        chk_bit("restored enable", 1'b1, enable_flag_o);
        pulse(clear_enable_i);
        chk_bit("cleared enable", 1'b0, enable_flag_o);
        $display("test return done");
        slave_present_i = 8'h10;
        request_inputs_i = 8'h10;
        pulse(set_enable_i);
        step(8);
        take(1'b0, 8'h3a, 1'b1, 3'h4);
        wr(cvec_pkg::CMD_PORT, cvec_pkg::END_OF_SERVICE_CMD);
        request_inputs_i = 8'h01;
        $display("test cascade done");
        pulse(set_enable_i);
        nmi_i = 1'b1;
        step(8);
        take(1'b1, 8'h00, 1'b0, 3'h0);
        nmi_i = 1'b0;
        $display("test non-maskable done");
        close_out();
    end

    // watchdog: the tests need about 120 cycles
    initial begin
        repeat (5000) @(posedge clock_i);
        bad_count++;
        close_out();
    end
endmodule // cvec_top_test

bind cvec_top cvec_top_chk u_cvec_top_chk (.clock_i(clock_i), .resetn_i(resetn_i), .ext_id_i(ext_id_i),
    .int_ack_o(int_ack_o), .push_flags_o(push_flags_o), .call_o(call_o), .vector_o(vector_o),
    .enable_flag_o(enable_flag_o), .cascade_oe_o(cascade_oe_o), .id_data_o(id_data_o),
    .id_data_oe_o(id_data_oe_o));
